// ### hw/spind_top.sv
// What this block does
// - Indicator negated when unconfigured or suspended.
// - Indicator asserted only when configured and active.
// - Self-power detect low means bus powered.
// - Self-power detect high means local power, except in the default bus-powered method.
// - Capture both strap bits at reset release.
// - Strap honoured only when method enables it.
// - Strap decodes to zero to three fixed ports.
// - Strap 00/10 active high, 01/11 active low.
// - Latch both method selects at reset release.
// - Default method lets straps override defaults.
// - Loaded values beat straps for serial-bus and external-memory methods.
`timescale 1ns/1ns
`default_nettype none
module spind_top
  import spind_pkg::*;
#(
  parameter int PORT_COUNT = 4,
  parameter int ADDR_WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  input wire logic fixed_port_strap_hi,
  input wire logic config_method_select_lo,
  input wire logic config_method_select_hi,
  output logic self_power,
  output logic [PORT_COUNT-1:0] fixed_ports,
  output logic [1:0] config_method
);

  // ---------------------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------------------
  if (PORT_COUNT != 4) begin : g_bad_port_count
    $error("Port count must be four.");
  end
  if (ADDR_WIDTH < 4 || ADDR_WIDTH > 8) begin : g_bad_addr_width
    $error("Address width must be four to eight bits.");
  end

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  spind_state_type state_reg, state_next;
  logic [1:0] strap_reg, strap_next;
  logic [1:0] method_reg, method_next;
  logic strap_en_reg, strap_en_next;
  logic active_low_reg, active_low_next;
  logic self_power_reg, self_power_next;
  logic [PORT_COUNT-1:0] fixed_reg, fixed_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic pin_out_reg, pin_out_next;
  logic pin_oe_n_reg, pin_oe_n_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;

  // ---------------------------------------------------------------------------
  // Internal signals
  // ---------------------------------------------------------------------------
  logic [1:0] pin_method;
  logic pin_strap_en;
  logic [1:0] fixed_strap;
  logic [1:0] capture_strap;
  logic [3:0] dec_fixed;
  logic dec_active_low;
  logic [PORT_COUNT-1:0] override_mask;
  logic override_use;
  logic ind_active;
  logic [2:0] addr_hit;
  logic setup_phase;
  logic access_write;
  logic [31:0] status_word;
  logic [31:0] config_word;

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  function automatic logic method_has_straps(input logic [1:0] m);
    return (m == SPIND_METHOD_DEFAULT_SELF) || (m == SPIND_METHOD_DEFAULT_BUS);
  endfunction

  function automatic logic [2:0] decode_addr(input logic [ADDR_WIDTH-1:0] a);
    logic [7:0] a8;
    a8 = 8'(a);
    return {a8 == SPIND_CONFIG_OFFSET, a8 == SPIND_STATUS_OFFSET, a8 == SPIND_CTRL_OFFSET};
  endfunction

  // ---------------------------------------------------------------------------
  // Strap sampling
  // ---------------------------------------------------------------------------
  assign pin_method = {config_method_select_hi, config_method_select_lo};
  assign pin_strap_en = method_has_straps(pin_method);
  assign fixed_strap = {fixed_port_strap_hi, pin_in};
  assign capture_strap = pin_strap_en ? fixed_strap : SPIND_STRAP_RESET;

  spind_strap_decode spind_strap_decode_inst (
    .strap(capture_strap),
    .fixed_ports(dec_fixed),
    .active_low(dec_active_low)
  );

  // ---------------------------------------------------------------------------
  // Capture state machine
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    method_next = method_reg;
    strap_en_next = strap_en_reg;
    strap_next = strap_reg;
    active_low_next = active_low_reg;
    unique case (state_reg)
      SPIND_IN_RESET: begin
        state_next = SPIND_CAPTURE;
      end
      SPIND_CAPTURE: begin
        method_next = pin_method;
        strap_en_next = pin_strap_en;
        strap_next = capture_strap;
        active_low_next = dec_active_low;
        state_next = SPIND_RUN;
      end
      SPIND_RUN: begin
        state_next = SPIND_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SPIND_IN_RESET;
      method_reg <= SPIND_METHOD_DEFAULT_SELF;
      strap_en_reg <= 1'b0;
      strap_reg <= SPIND_STRAP_RESET;
      active_low_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      method_reg <= method_next;
      strap_en_reg <= strap_en_next;
      strap_reg <= strap_next;
      active_low_reg <= active_low_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Self-power sense
  // ---------------------------------------------------------------------------
  always_comb begin
    self_power_next = self_power_reg;
    if (state_reg != SPIND_RUN) begin
      self_power_next = pin_in;
    end
    if (method_next == SPIND_METHOD_DEFAULT_BUS) begin
      self_power_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      self_power_reg <= 1'b0;
    end else begin
      self_power_reg <= self_power_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Fixed-port mask
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < PORT_COUNT; i++) begin : g_override
    assign override_mask[i] = ctrl_reg[SPIND_CTRL_OVR_LO_BIT + i];
  end
  assign override_use = !strap_en_reg && ctrl_reg[SPIND_CTRL_OVR_VALID_BIT];

  always_comb begin
    fixed_next = fixed_reg;
    if (state_reg == SPIND_CAPTURE) begin
      fixed_next = PORT_COUNT'(dec_fixed);
    end else if (state_reg == SPIND_RUN && override_use) begin
      fixed_next = override_mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_reg <= SPIND_FIXED_RESET;
    end else begin
      fixed_reg <= fixed_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Indicator pin
  // ---------------------------------------------------------------------------
  assign ind_active = ctrl_reg[SPIND_CTRL_CONFIGURED_BIT] &&
                      !ctrl_reg[SPIND_CTRL_SUSPENDED_BIT];

  always_comb begin
    pin_oe_n_next = pin_oe_n_reg;
    pin_out_next = 1'b0;
    if (state_next == SPIND_RUN) begin
      pin_oe_n_next = 1'b0;
      pin_out_next = ind_active ^ active_low_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_reg <= 1'b0;
      pin_oe_n_reg <= 1'b1;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_n_reg <= pin_oe_n_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  assign addr_hit = decode_addr(paddr);
  assign setup_phase = psel && !penable;
  assign access_write = psel && penable && pready_reg && pwrite;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (access_write && addr_hit[0]) begin
      ctrl_next = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= SPIND_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Read words
  // ---------------------------------------------------------------------------
  always_comb begin
    status_word = SPIND_READ_ZERO;
    status_word[SPIND_STATUS_SELF_POWER_BIT] = self_power_reg;
    status_word[SPIND_STATUS_IND_ACTIVE_BIT] = ind_active;
    status_word[SPIND_STATUS_ACTIVE_LOW_BIT] = active_low_reg;
    status_word[SPIND_STATUS_STRAP_EN_BIT] = strap_en_reg;
    status_word[SPIND_STATUS_DRIVING_BIT] = !pin_oe_n_reg;
    status_word[SPIND_STATUS_FIXED_LO_BIT +: PORT_COUNT] = fixed_reg;
    config_word = SPIND_READ_ZERO;
    config_word[SPIND_CONFIG_METHOD_LO_BIT +: 2] = method_reg;
    config_word[SPIND_CONFIG_METHOD_LO_BIT + 2 +: 2] = strap_reg;
  end

  // ---------------------------------------------------------------------------
  // APB response
  // ---------------------------------------------------------------------------
  always_comb begin
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    if (setup_phase) begin
      pready_next = 1'b1;
      pslverr_next = !(|addr_hit);
      prdata_next = SPIND_READ_ZERO;
      if (!pwrite && addr_hit[0]) begin
        prdata_next[7:0] = ctrl_reg;
      end else if (!pwrite && addr_hit[1]) begin
        prdata_next = status_word;
      end else if (!pwrite && addr_hit[2]) begin
        prdata_next = config_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= SPIND_READ_ZERO;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe_n = pin_oe_n_reg;
  assign self_power = self_power_reg;
  assign fixed_ports = fixed_reg;
  assign config_method = method_reg;

endmodule
`default_nettype wire

// ### hw/spind_pkg.sv
package spind_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SPIND_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] SPIND_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] SPIND_CONFIG_OFFSET = 8'h08;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int SPIND_CTRL_CONFIGURED_BIT = 0;
  localparam int SPIND_CTRL_SUSPENDED_BIT = 1;
  localparam int SPIND_CTRL_OVR_VALID_BIT = 2;
  localparam int SPIND_CTRL_OVR_LO_BIT = 4;
  localparam int SPIND_CTRL_OVR_HI_BIT = 7;
  localparam int SPIND_STATUS_SELF_POWER_BIT = 0;
  localparam int SPIND_STATUS_IND_ACTIVE_BIT = 1;
  localparam int SPIND_STATUS_ACTIVE_LOW_BIT = 2;
  localparam int SPIND_STATUS_STRAP_EN_BIT = 3;
  localparam int SPIND_STATUS_DRIVING_BIT = 4;
  localparam int SPIND_STATUS_FIXED_LO_BIT = 8;
  localparam int SPIND_CONFIG_METHOD_LO_BIT = 0;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SPIND_CTRL_RESET = 8'h00;
  localparam logic [1:0] SPIND_STRAP_RESET = 2'h0;
  localparam logic [3:0] SPIND_FIXED_RESET = 4'h0;
  localparam logic [31:0] SPIND_READ_ZERO = 32'h00000000;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SPIND_METHOD_DEFAULT_SELF = 2'b00,
    SPIND_METHOD_SERIAL_BUS = 2'b01,
    SPIND_METHOD_DEFAULT_BUS = 2'b10,
    SPIND_METHOD_EXT_MEMORY = 2'b11
  } spind_method_type;

  typedef enum {SPIND_IN_RESET, SPIND_CAPTURE, SPIND_RUN} spind_state_type;

endpackage

// ### hw/spind_strap_decode.sv
`timescale 1ns/1ns
`default_nettype none
module spind_strap_decode
  import spind_pkg::*;
(
  input wire logic [1:0] strap,
  output logic [3:0] fixed_ports,
  output logic active_low
);

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  always_comb begin
    unique case (strap)
      2'b00: fixed_ports = 4'h0;
      2'b01: fixed_ports = 4'h1;
      2'b10: fixed_ports = 4'h3;
      2'b11: fixed_ports = 4'h7;
    endcase
    active_low = strap[0];
  end

endmodule
`default_nettype wire

// ### sim/spind_board.sv
`timescale 1ns/1ns
`default_nettype none
module spind_board (
  input wire logic pin_out,
  input wire logic pin_oe_n,
  input wire logic strap_level,
  output logic pin_level
);
  // Strap resistor sets the released pin; the indicator wins when driven.
  assign pin_level = pin_oe_n ? strap_level : pin_out;
endmodule
`default_nettype wire

// ### sim/spind_sva.sv
`timescale 1ns/1ns
`default_nettype none
module spind_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pin_oe_n,
  input wire logic self_power,
  input wire logic [3:0] fixed_ports,
  input wire logic [1:0] config_method
);
  // --------------------------------
  // Pin, strap and bus properties.
  // --------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_OE_START: assert property ($rose(presetn) |-> pin_oe_n ##[1:2] !pin_oe_n)
    else $error("pin drive start wrong");
  AST_OE_HOLD: assert property (!pin_oe_n |=> !pin_oe_n)
    else $error("pin drive dropped");
  AST_RST_ZERO: assert property ($rose(presetn) |-> fixed_ports == 4'h0)
    else $error("fixed ports not clear");
  AST_METHOD_HOLD: assert property (!pin_oe_n |=> $stable(config_method))
    else $error("method changed");
  AST_DECODE: assert property (!pin_oe_n && !config_method[0] |->
    fixed_ports inside {4'h0, 4'h1, 4'h3, 4'h7})
    else $error("bad fixed mask");
  AST_STRAP_HOLD: assert property (!pin_oe_n && !config_method[0] |=> $stable(fixed_ports))
    else $error("fixed mask changed");
  AST_BUS_POWER: assert property (!pin_oe_n && config_method == 2'h2 |-> !self_power)
    else $error("bus power ignored");
  AST_SELF_HOLD: assert property (!pin_oe_n |=> $stable(self_power))
    else $error("power sense changed");
  AST_PREADY: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready timing wrong");
  cover property (!pin_oe_n && fixed_ports == 4'h7);
  cover property (!pin_oe_n && config_method == 2'h2);
  cover property (pready);
endmodule
bind spind_top spind_sva spind_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pin_oe_n(pin_oe_n), .self_power(self_power),
  .fixed_ports(fixed_ports), .config_method(config_method));
`default_nettype wire

// ### sim/spind_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t mismatch %h %h", $time, a, b); end end
module spind_top_bench;
  import spind_pkg::*;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pin_in, pin_out, pin_oe_n, pready, pslverr;
  logic s_hi, s_lo, c_hi, c_lo, self_power, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] fixed_ports;
  logic [1:0] config_method;
  int fail_count = 0;
  int total_checks = 0;
  always #4 pclk = ~pclk;
  spind_board spind_board_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .strap_level(s_lo),
    .pin_level(pin_in));
  spind_top spind_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .fixed_port_strap_hi(s_hi), .config_method_select_lo(c_lo),
    .config_method_select_hi(c_hi), .self_power(self_power), .fixed_ports(fixed_ports),
    .config_method(config_method));
  // --------------------------------
  // Helpers.
  // --------------------------------
  function automatic logic [3:0] exp_fixed(input logic [1:0] st);
    return (4'h1 << st) - 4'h1;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic run(input logic [3:0] v);
    logic [1:0] st;
    logic [3:0] mask;
    presetn <= 1'b0;
    {c_hi, c_lo, s_hi, s_lo} <= v;
    repeat (3) @(posedge pclk);
    `CHK(pin_oe_n, 1'b1)
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    st = v[2] ? 2'h0 : v[1:0];
    mask = 4'($urandom);
    `CHK(pin_oe_n, 1'b0)
    `CHK(config_method, v[3:2])
    `CHK(fixed_ports, exp_fixed(st))
    `CHK(self_power, (v[3:2] == 2'h2) ? 1'b0 : v[0])
    `CHK(pin_out, st[0])
    apb(1'b1, 8'h00, 32'h00000001 | ($urandom & 32'h000000F0));
    @(posedge pclk);
    `CHK(pin_out, ~st[0])
    apb(1'b1, 8'h00, 32'h00000003);
    @(posedge pclk);
    `CHK(pin_out, st[0])
    apb(1'b0, 8'h04, 32'h00000000);
    `CHK(rdata[2], st[0])
    `CHK(rdata[3], ~v[2])
    `CHK(rdata[11:8], exp_fixed(st))
    apb(1'b0, 8'h08, 32'h00000000);
    `CHK(rdata[3:0], {st, v[3:2]})
    apb(1'b0, 8'h0C, 32'h00000000);
    `CHK(rerr, 1'b1)
    apb(1'b1, 8'h00, {24'h000000, mask, 4'h4});
    @(posedge pclk);
    `CHK(fixed_ports, v[2] ? mask : exp_fixed(st))
  endtask
  // --------------------------------
  // Main sequence and watchdog.
  // --------------------------------
  initial begin
    {psel, penable, pwrite, presetn, s_hi, s_lo, c_hi, c_lo} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    void'($urandom(32'hE8E7));
    for (int i = 0; i < 24; i++) begin
      run((i < 16) ? 4'(i) : 4'($urandom));
    end
    end_sim;
  end
  initial begin
    #60000;
    fail_count++;
    end_sim;
  end
endmodule
`default_nettype wire
